// [dv/flash_model.sv]
/*
  Behavioural byte-wide flash for the sequencer's far side.
  Sampled on the bench clock; the bench commands lock, fault and delay cases.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  // Clock and pins
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] din_i,
  input wire logic din_oe_i,
  input wire logic reset_powerdown_n_i,
  output logic [7:0] dq_o,
  output logic rb_o,
  // Bench controls
  input wire logic master_i,
  input wire logic fail_i,
  input wire logic supply_i,
  input wire logic seq_i,
  input wire logic slow_i
);
  logic [7:0] mem [256];
  logic [7:0] sr_r = 8'h80;
  logic [7:0] setup_r = 8'h00;
  logic [7:0] wd_r;
  logic [7:0] last_r = 8'h00;
  logic [19:0] wa_r;
  logic [15:0] lock_r = 16'h0000;
  logic pend_r = 1'b0;
  logic stat_r = 1'b0;
  logic drive;
  int busy = 0;
  // Released bus shows the inverse of its last value, never a stale copy.
  assign drive = !ce_n_i && !oe_n_i && reset_powerdown_n_i;
  assign dq_o = drive ? (stat_r ? sr_r : mem[addr_i[7:0]])
                      : (din_oe_i ? din_i : ~last_r);
  assign rb_o = (busy == 0);
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // --------------------------------------------------------------------
  // Command interpreter
  // --------------------------------------------------------------------
  task automatic cmd(input logic [19:0] a, input logic [7:0] d);
    int eb;
    logic ok;
    eb = (setup_r == 8'h40 || (setup_r == 8'h60 && d != 8'hD0)) ? 4 : 5;
    ok = !seq_i && (setup_r == 8'h40 || (setup_r == 8'h20 && d == 8'hD0) ||
         (setup_r == 8'h60 && d inside {8'h01, 8'hF1, 8'hD0}));
    if (busy != 0) return;
    if (setup_r == 8'h00) begin
      if (d == 8'hFF) stat_r = 1'b0;
      if (d == 8'h50) sr_r[5:1] = 5'h00;
      if (d inside {8'h40, 8'h20, 8'h60, 8'h70}) stat_r = 1'b1;
      if (d inside {8'h40, 8'h20, 8'h60}) setup_r = d;
      return;
    end
    stat_r = 1'b1;
    if (!ok) sr_r[5:4] = 2'b11;
    else begin
      busy = slow_i ? 600 : 30;
      sr_r[7] = 1'b0;
      if (supply_i) begin
        sr_r[3] = 1'b1;
        sr_r[eb] = 1'b1;
      end else if ((setup_r != 8'h60 && lock_r[a[19:16]]) ||
                   (setup_r == 8'h60 && (d == 8'hF1 || master_i))) begin
        sr_r[1] = 1'b1;
      end else if (fail_i) sr_r[eb] = 1'b1;
      else if (setup_r == 8'h40) mem[a[7:0]] = d;
      else if (setup_r == 8'h20) foreach (mem[i]) mem[i] = 8'hFF;
      else lock_r = (d == 8'h01) ? lock_r | (16'h0001 << a[19:16]) : 16'h0000;
    end
    setup_r = 8'h00;
  endtask : cmd
  always @(posedge clk_i) begin
    if (!reset_powerdown_n_i) begin
      sr_r = 8'h80;
      stat_r = 1'b0;
      setup_r = 8'h00;
      pend_r = 1'b0;
      busy = 0;
    end else begin
      if (drive) last_r = dq_o;
      if (busy == 1) sr_r[7] = 1'b1;
      if (busy > 0) busy--;
      if (!ce_n_i && !we_n_i) begin
        wa_r = addr_i;
        wd_r = din_i;
        pend_r = 1'b1;
      end else if (pend_r) begin
        pend_r = 1'b0;
        cmd(wa_r, wd_r);
      end
    end
  end
endmodule : flash_model
`default_nettype wire

// [dv/flash_sequencer_bench.sv]
/*
  Self-checking bench for flash_sequencer with a behavioural flash.
  Drives classic Wishbone from the clock edge; judges the STAT register.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_sequencer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_o, ready_busy_pin_i;
  logic reset_powerdown_n_o;
  logic [19:0] flash_addr_o;
  logic [7:0] flash_dq_o, flash_dq_i;
  logic master = 1'b0, fail = 1'b0, supply = 1'b0, seq = 1'b0, slow = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  always #2.5 clk_i = ~clk_i;
  flash_sequencer #(.POLL_LIMIT(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o), .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i),
    .ready_busy_pin_i(ready_busy_pin_i), .reset_powerdown_n_o(reset_powerdown_n_o));
  flash_model u_flash (
    .clk_i(clk_i), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .addr_i(flash_addr_o), .din_i(flash_dq_o), .din_oe_i(flash_dq_oe_o),
    .reset_powerdown_n_i(reset_powerdown_n_o), .dq_o(flash_dq_i), .rb_o(ready_busy_pin_i),
    .master_i(master), .fail_i(fail), .supply_i(supply), .seq_i(seq), .slow_i(slow));
  task automatic finish_test;
    $display("Compared %0d values, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask : wb
  // Starts one operation and polls STAT until the busy bit drops.
  task automatic op(input logic [2:0] o, input logic [19:0] a, input logic c);
    logic [31:0] q;
    int n;
    wb(1'b1, flash_seq_pkg::REG_ADDR, {12'h000, a}, q);
    wb(1'b1, flash_seq_pkg::REG_CTRL, {28'h000_0000, c, o}, q);
    n = 0;
    q = 32'h0000_0001;
    while (q[0] !== 1'b0 && n < 500) begin
      wb(1'b0, flash_seq_pkg::REG_STAT, 32'h0000_0000, q);
      n++;
    end
    if (q[0] !== 1'b0) begin
      err_count++;
      finish_test();
    end
  endtask : op
  // Expects last flash status, ready pin high, outcome code and pending flag.
  task automatic stat(input logic [7:0] sr, input logic [2:0] res);
    logic [31:0] q;
    wb(1'b0, flash_seq_pkg::REG_STAT, 32'h0000_0000, q);
    compare("STAT", {16'h0000, sr, 8'h40} | {27'h000_0000, res != 3'h0, res, 1'b0},
            q & 32'h0000_FF7F);
  endtask : stat
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, 4'h2, 32'h0000_0000, q);
    compare("unmapped read", 32'h0000_0000, q);
    compare("chip enable idle", 32'h0000_0001, {31'h0, flash_ce_n_o});
  endtask : t_reset
  task automatic t_write_read;
    logic [31:0] q;
    wb(1'b1, flash_seq_pkg::REG_DATA, 32'h0000_00A5, q);
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h0_0012, 1'b1);
    stat(8'h80, flash_seq_pkg::RES_OK);
    op(flash_seq_pkg::OP_READ_ARRAY, 20'h0_0000, 1'b0);
    op(flash_seq_pkg::OP_READ, 20'h0_0012, 1'b0);
    wb(1'b0, flash_seq_pkg::REG_ADDR, 32'h0000_0000, q);
    compare("address readback", 32'h0000_0012, q);
    wb(1'b0, flash_seq_pkg::REG_DATA, 32'h0000_0000, q);
    compare("array byte", 32'h0000_00A5, q);
  endtask : t_write_read
  task automatic t_lock_sticky;
    op(flash_seq_pkg::OP_BLOCK_LOCK, 20'h1_0000, 1'b1);
    stat(8'h80, flash_seq_pkg::RES_OK);
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h1_0003, 1'b0);
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h0_0003, 1'b1);
    stat(8'h82, flash_seq_pkg::RES_PROTECT);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h0_0003, 1'b1);
    stat(8'h80, flash_seq_pkg::RES_OK);
  endtask : t_lock_sticky
  task automatic t_master;
    op(flash_seq_pkg::OP_MASTER_LOCK, 20'h3_1234, 1'b1);
    stat(8'h82, flash_seq_pkg::RES_PROTECT);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    master <= 1'b1;
    op(flash_seq_pkg::OP_BLOCK_LOCK, 20'h2_0000, 1'b1);
    stat(8'h82, flash_seq_pkg::RES_PROTECT);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    op(flash_seq_pkg::OP_CLEAR_LOCKS, 20'h0_0000, 1'b1);
    stat(8'h82, flash_seq_pkg::RES_PROTECT);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    master <= 1'b0;
    op(flash_seq_pkg::OP_CLEAR_LOCKS, 20'h5_5555, 1'b1);
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h1_0003, 1'b1);
    stat(8'h80, flash_seq_pkg::RES_OK);
  endtask : t_master
  task automatic t_faults;
    fail <= 1'b1;
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h0_0040, 1'b1);
    stat(8'h90, flash_seq_pkg::RES_OP_FAIL);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    op(flash_seq_pkg::OP_BLOCK_ERASE, 20'h0_0000, 1'b1);
    stat(8'hA0, flash_seq_pkg::RES_OP_FAIL);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    supply <= 1'b1;
    op(flash_seq_pkg::OP_BLOCK_ERASE, 20'h0_0000, 1'b1);
    stat(8'hA8, flash_seq_pkg::RES_SUPPLY);
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
    supply <= 1'b0;
    fail <= 1'b0;
    seq <= 1'b1;
    op(flash_seq_pkg::OP_BYTE_WRITE, 20'h0_0041, 1'b1);
    stat(8'hB0, flash_seq_pkg::RES_SEQUENCE);
    seq <= 1'b0;
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0000, 1'b0);
  endtask : t_faults
  task automatic t_timeout;
    logic [31:0] q;
    slow <= 1'b1;
    wb(1'b1, flash_seq_pkg::REG_ADDR, 32'h0000_0050, q);
    wb(1'b1, flash_seq_pkg::REG_CTRL, 32'h0000_0009, q);
    // A control write while busy is acknowledged and ignored.
    op(flash_seq_pkg::OP_CLEAR_STATUS, 20'h0_0050, 1'b0);
    wb(1'b0, flash_seq_pkg::REG_STAT, 32'h0000_0000, q);
    compare("timeout flag", 32'h0000_0001, {31'h0, q[5]});
    wb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0000_0000, q);
    compare("refused control", 32'h0000_0009, q);
  endtask : t_timeout
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_write_read();
    t_lock_sticky();
    t_master();
    t_faults();
    t_timeout();
    finish_test();
  end
endmodule : flash_sequencer_bench
`default_nettype wire

// [dv/flash_sequencer_sva.sv]
/*
  Port checker for flash_sequencer: bus handshake and flash strobe timing.
  Bound to every flash_sequencer instance; sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_sequencer_sva (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Flash pins
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic [19:0] flash_addr_o,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counts the cycles that chip-enable has been low.
  logic [7:0] low_r;
  always_ff @(posedge clk_i) begin
    low_r <= (rst_i || flash_ce_n_o) ? 8'h00 : low_r + 8'h01;
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_end; $rose(flash_ce_n_o); endsequence
  property p_ack; s_req |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held too long");
  property p_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_width; s_end |-> low_r == 8'(flash_seq_pkg::STROBE_CYC); endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_gap; s_end |-> flash_ce_n_o [*6]; endproperty
  a_gap: assert property (p_gap) else $error("recovery gap too short");
  property p_hold;
    !flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved in strobe");
  property p_read; !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o; endproperty
  a_read: assert property (p_read) else $error("read strobe clash");
  property p_write; !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o; endproperty
  a_write: assert property (p_write) else $error("write without data");
endmodule : flash_sequencer_sva
bind flash_sequencer flash_sequencer_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o)
);
`default_nettype wire

// [rtl/flash_bus_cycle.sv]
/*
  One asynchronous flash bus cycle, read or write, with strobe and recovery timing.
  Latches the request when start_i is seen in idle and assumes that dq_i is already
  synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire flash_seq_pkg::cycle_req_s req_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Flash data in, synchronised
  input wire logic [7:0] dq_i,
  // Pins
  output flash_seq_pkg::flash_pins_s pins_o
);

  typedef enum logic [1:0] {CY_IDLE, CY_STROBE, CY_GAP} cycle_e;
  cycle_e state_r;
  logic [7:0] cnt_r;

  // ----------------------------------------------------------------------
  // Strobe sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      state_r <= CY_IDLE;
      cnt_r <= 8'h00;
      rdata_o <= 8'h00;
      pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h0_0000,
                  dq_out: 8'h00, dq_oe: 1'b0};
    end else begin
      unique case (state_r)
        CY_IDLE: begin
          if (start_i) begin
            // The flash drives its outputs only while selected and read-enabled.
            pins_o.ce_n <= 1'b0;
            pins_o.addr <= req_i.addr;
            pins_o.we_n <= ~req_i.we;
            pins_o.oe_n <= req_i.we;
            pins_o.dq_oe <= req_i.we;
            pins_o.dq_out <= req_i.data;
            cnt_r <= 8'(flash_seq_pkg::STROBE_CYC);
            state_r <= CY_STROBE;
          end
        end
        CY_STROBE: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            rdata_o <= dq_i;
            pins_o.ce_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            pins_o.we_n <= 1'b1;
            cnt_r <= 8'(flash_seq_pkg::GAP_CYC);
            state_r <= CY_GAP;
          end
        end
        CY_GAP: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            pins_o.dq_oe <= 1'b0;
            done_o <= 1'b1;
            state_r <= CY_IDLE;
          end
        end
        default: state_r <= CY_IDLE;
      endcase
    end
  end

endmodule : flash_bus_cycle
`default_nettype wire

// [rtl/flash_sequencer.sv]
/*
  Host-side command and status sequencer for an asynchronous parallel flash.
  Software writes address, data and an operation over classic Wishbone; the block
  issues the two-cycle command, polls ready, runs the full status check and
  reports an outcome code. Assumes the flash pins run asynchronously to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_sequencer #(
  parameter int POLL_LIMIT = 65535
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [19:0] flash_addr_o,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [7:0] flash_dq_i,
  input wire logic ready_busy_pin_i,
  output logic reset_powerdown_n_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_FIRST, S_SECOND, S_POLL_RD, S_POLL_WAIT, S_CHECK, S_ARRAY, S_READ_DO
  } seq_e;

  seq_e state_r;
  logic [19:0] addr_r;
  logic [7:0] data_r;
  logic [2:0] op_r;
  logic check_each_r;
  logic busy_r;
  logic [2:0] result_r;
  logic [7:0] last_status_r;
  logic [7:0] read_data_r;
  logic error_pending_r;
  logic timeout_r;
  logic [15:0] poll_cnt_r;
  logic [7:0] dq_meta_r, dq_sync_r;
  logic rb_meta_r, rb_sync_r;
  logic cyc_start_r;
  flash_seq_pkg::cycle_req_s req_r;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  flash_seq_pkg::flash_pins_s pins;
  logic wb_hit;
  logic go;

  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign go = wb_hit && we_i && adr_i == flash_seq_pkg::REG_CTRL && sel_i[0] && !busy_r;

  // ----------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    dq_meta_r <= flash_dq_i;
    dq_sync_r <= dq_meta_r;
    rb_meta_r <= ready_busy_pin_i;
    rb_sync_r <= rb_meta_r;
  end

  flash_bus_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start_r),
    .req_i(req_r),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .dq_i(dq_sync_r),
    .pins_o(pins)
  );

  always_ff @(posedge clk_i) begin
    flash_ce_n_o <= pins.ce_n;
    flash_oe_n_o <= pins.oe_n;
    flash_we_n_o <= pins.we_n;
    flash_addr_o <= pins.addr;
    flash_dq_o <= pins.dq_out;
    flash_dq_oe_o <= pins.dq_oe;
    reset_powerdown_n_o <= !rst_i;
  end

  // ----------------------------------------------------------------------
  // Wishbone register access
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      addr_r <= 20'h0_0000;
      data_r <= 8'h00;
      op_r <= flash_seq_pkg::OP_READ;
      check_each_r <= 1'b1;
    end else begin
      ack_o <= wb_hit;
      if (wb_hit && we_i) begin
        unique case (adr_i)
          flash_seq_pkg::REG_ADDR: if (sel_i[0]) addr_r <= dat_i[19:0];
          flash_seq_pkg::REG_DATA: if (sel_i[0]) data_r <= dat_i[7:0];
          flash_seq_pkg::REG_CTRL: begin
            if (go) begin
              op_r <= dat_i[2:0];
              check_each_r <= dat_i[3];
            end
          end
          default: ;
        endcase
      end
      if (wb_hit && !we_i) begin
        unique case (adr_i)
          flash_seq_pkg::REG_ADDR: dat_o <= {12'h000, addr_r};
          flash_seq_pkg::REG_DATA: dat_o <= {24'h00_0000, read_data_r};
          flash_seq_pkg::REG_CTRL: dat_o <= {28'h000_0000, check_each_r, op_r};
          flash_seq_pkg::REG_STAT: dat_o <= {16'h0000, last_status_r, 1'b0, rb_sync_r,
                                             timeout_r, error_pending_r, result_r, busy_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    cyc_start_r <= 1'b0;
    if (rst_i) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      result_r <= flash_seq_pkg::RES_OK;
      last_status_r <= 8'h00;
      read_data_r <= 8'h00;
      error_pending_r <= 1'b0;
      timeout_r <= 1'b0;
      poll_cnt_r <= 16'h0000;
      req_r <= '0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (go) begin
            busy_r <= 1'b1;
            timeout_r <= 1'b0;
            cyc_start_r <= 1'b1;
            req_r.we <= 1'b1;
            req_r.addr <= addr_r;
            state_r <= S_FIRST;
            unique case (dat_i[2:0])
              flash_seq_pkg::OP_BYTE_WRITE: req_r.data <= flash_seq_pkg::CMD_BYTE_WRITE;
              flash_seq_pkg::OP_BLOCK_ERASE: begin
                req_r.data <= flash_seq_pkg::CMD_ERASE_SETUP;
              end
              flash_seq_pkg::OP_BLOCK_LOCK,
              flash_seq_pkg::OP_MASTER_LOCK: req_r.data <= flash_seq_pkg::CMD_LOCK_SETUP;
              flash_seq_pkg::OP_CLEAR_LOCKS: req_r.data <= flash_seq_pkg::CMD_LOCK_SETUP;
              flash_seq_pkg::OP_CLEAR_STATUS: begin
                req_r.data <= flash_seq_pkg::CMD_CLEAR_STATUS;
                error_pending_r <= 1'b0;
                state_r <= S_ARRAY;
              end
              flash_seq_pkg::OP_READ_ARRAY: begin
                req_r.data <= flash_seq_pkg::CMD_READ_ARRAY;
                state_r <= S_ARRAY;
              end
              default: begin
                req_r.we <= 1'b0;
                state_r <= S_READ_DO;
              end
            endcase
          end
        end
        S_FIRST: begin
          if (cyc_done) begin
            cyc_start_r <= 1'b1;
            unique case (op_r)
              flash_seq_pkg::OP_BYTE_WRITE: req_r.data <= data_r;
              flash_seq_pkg::OP_BLOCK_LOCK: req_r.data <= flash_seq_pkg::CMD_BLOCK_LOCK;
              flash_seq_pkg::OP_MASTER_LOCK: req_r.data <= flash_seq_pkg::CMD_MASTER_LOCK;
              default: req_r.data <= flash_seq_pkg::CMD_CONFIRM;
            endcase
            state_r <= S_SECOND;
          end
        end
        S_SECOND: begin
          if (cyc_done) begin
            poll_cnt_r <= 16'(POLL_LIMIT);
            cyc_start_r <= 1'b1;
            req_r.we <= 1'b0;
            state_r <= S_POLL_RD;
          end
        end
        S_POLL_RD: begin
          // Reads now return the status register until array read is written.
          if (cyc_done) begin
            last_status_r <= cyc_rdata;
            state_r <= S_POLL_WAIT;
          end
        end
        S_POLL_WAIT: begin
          if (last_status_r[flash_seq_pkg::STATUS_READY_BIT] && rb_sync_r) begin
            state_r <= S_CHECK;
          end else if (poll_cnt_r == 16'h0000) begin
            timeout_r <= 1'b1;
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end else begin
            poll_cnt_r <= poll_cnt_r - 16'h0001;
            cyc_start_r <= 1'b1;
            state_r <= S_POLL_RD;
          end
        end
        S_CHECK: begin
          busy_r <= 1'b0;
          state_r <= S_IDLE;
          if (!check_each_r) begin
            result_r <= flash_seq_pkg::RES_OK;
          end else if (last_status_r[flash_seq_pkg::STATUS_SUPPLY_ERROR]) begin
            result_r <= flash_seq_pkg::RES_SUPPLY;
          end else if (last_status_r[flash_seq_pkg::STATUS_PROTECT_DETECT]) begin
            result_r <= flash_seq_pkg::RES_PROTECT;
          end else if (last_status_r[flash_seq_pkg::STATUS_WRITE_SET_ERROR]
                       && last_status_r[flash_seq_pkg::STATUS_ERASE_CLEAR_ERROR]) begin
            result_r <= flash_seq_pkg::RES_SEQUENCE;
          end else if (last_status_r[flash_seq_pkg::STATUS_WRITE_SET_ERROR]
                       || last_status_r[flash_seq_pkg::STATUS_ERASE_CLEAR_ERROR]) begin
            result_r <= flash_seq_pkg::RES_OP_FAIL;
          end else begin
            result_r <= flash_seq_pkg::RES_OK;
          end
          // Flags sticky errors so that software clears status before any retry.
          if (|{last_status_r[flash_seq_pkg::STATUS_SUPPLY_ERROR],
                last_status_r[flash_seq_pkg::STATUS_PROTECT_DETECT],
                last_status_r[flash_seq_pkg::STATUS_WRITE_SET_ERROR],
                last_status_r[flash_seq_pkg::STATUS_ERASE_CLEAR_ERROR]}) begin
            error_pending_r <= 1'b1;
          end
        end
        S_ARRAY: begin
          if (cyc_done) begin
            if (req_r.data == flash_seq_pkg::CMD_CLEAR_STATUS) begin
              last_status_r <= 8'h00;
              result_r <= flash_seq_pkg::RES_OK;
            end
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        S_READ_DO: begin
          if (cyc_done) begin
            read_data_r <= cyc_rdata;
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule : flash_sequencer
`default_nettype wire

// [shared/flash_seq_pkg.sv]
/*
  Package for the flash command sequencer: command codes, status bit positions,
  bus timing counts, controller register map and packed carriers.
  Assumes a 200 MHz clock and an asynchronous byte-wide flash on the far side.
*/
package flash_seq_pkg;

  // ----------------------------------------------------------------------
  // Flash command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_BYTE_WRITE = 8'h40;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_BLOCK_LOCK = 8'h01;
  localparam logic [7:0] CMD_MASTER_LOCK = 8'hF1;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // ----------------------------------------------------------------------
  // Flash status bits
  // ----------------------------------------------------------------------
  localparam int STATUS_READY_BIT = 7;
  localparam int STATUS_ERASE_CLEAR_ERROR = 5;
  localparam int STATUS_WRITE_SET_ERROR = 4;
  localparam int STATUS_SUPPLY_ERROR = 3;
  localparam int STATUS_PROTECT_DETECT = 1;

  // ----------------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS = 30;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Controller register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;

  // Operation selector written into the control register.
  localparam logic [2:0] OP_BYTE_WRITE = 3'h1;
  localparam logic [2:0] OP_BLOCK_ERASE = 3'h2;
  localparam logic [2:0] OP_BLOCK_LOCK = 3'h3;
  localparam logic [2:0] OP_MASTER_LOCK = 3'h4;
  localparam logic [2:0] OP_CLEAR_LOCKS = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;
  localparam logic [2:0] OP_READ_ARRAY = 3'h7;
  localparam logic [2:0] OP_READ = 3'h0;

  // Outcome codes reported by the full status check.
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_SUPPLY = 3'h1;
  localparam logic [2:0] RES_PROTECT = 3'h2;
  localparam logic [2:0] RES_SEQUENCE = 3'h3;
  localparam logic [2:0] RES_OP_FAIL = 3'h4;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic [19:0] addr;
    logic [7:0] data;
  } cycle_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } flash_pins_s;

endpackage : flash_seq_pkg
